// ===== rtl/smp_defs.svh
// Purpose: Shared constants of the serial port: addresses, bit fields, reset values.
// Assumes: Included by bare name from every design file that needs it.
// Notes on behaviour
// - Control top bit picks 8- or 9-bit frames
// - 8-bit frame: start, eight data LSB first, stop
// - 9-bit frame: start, eight data, ninth, stop
// - Buffer write starts transmission of the byte
// - Transmit-done set at start of stop bit
// - Receiver accepts characters only while enabled
// - 8-bit load needs done clear, stop checked only with match check on
// - Load stores byte, ninth bit, sets flag
// - Overrun keeps first byte, drops the later
// - Ninth transmit bit sent only in 9-bit mode
// - 9-bit: ninth bit stored, stop bit ignored
// - Either done flag requests an enabled interrupt
// - Receive-done set when stop bit is sampled
// - Done flags cleared only by software writes
// - Control bit 6 reads one, ignores writes
// - Writes reach transmitter, reads return receive latch
// - Bit clock is timer overflow rate halved
// - Start edge forces receive timer reload
`ifndef SMP_DEFS_SVH
`define SMP_DEFS_SVH

// ==========================================================
// Register addresses
`define SMP_ADDR_CTRL      8'h98
`define SMP_ADDR_BUF       8'h99

// ==========================================================
// Control register fields and reset value
`define SMP_CTRL_MODE      7
`define SMP_CTRL_ONE       6
`define SMP_CTRL_MCE       5
`define SMP_CTRL_REN       4
`define SMP_CTRL_TB8       3
`define SMP_CTRL_RB8       2
`define SMP_CTRL_TI        1
`define SMP_CTRL_RI        0
`define SMP_CTRL_RESET     8'h40

// ==========================================================
// Frame and buffering figures
`define SMP_DATA_BITS      8
`define SMP_TX_FIFO_DEPTH  8

`endif

// ===== rtl/smp_pkg.sv
// Purpose: Types shared by the serial port design.
// Assumes: Constants live in smp_defs.svh.
// Notes: One-hot state codes are written out.
`default_nettype none

package smp_pkg;

  // ==========================================================
  // Transmit sequencer
  typedef enum logic [5:0] {
    SMP_TX_IDLE  = 6'h01,
    SMP_TX_WAIT  = 6'h02,
    SMP_TX_START = 6'h04,
    SMP_TX_DATA  = 6'h08,
    SMP_TX_NINTH = 6'h10,
    SMP_TX_STOP  = 6'h20
  } smp_tx_state_t;

  // ==========================================================
  // Receive sequencer
  typedef enum logic [4:0] {
    SMP_RX_IDLE  = 5'h01,
    SMP_RX_START = 5'h02,
    SMP_RX_DATA  = 5'h04,
    SMP_RX_NINTH = 5'h08,
    SMP_RX_STOP  = 5'h10
  } smp_rx_state_t;

endpackage

`default_nettype wire

// ===== rtl/smp_fifo.sv
// Purpose: Small FIFO with a registered output word.
// Assumes: Single clock, synchronous reset, clock enable freezes all state.
// Notes: Holds DEPTH words in memory plus one in the output register.
`default_nettype none

module smp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push;
  wire              pop;
  wire              mem_empty;

  assign mem_empty = (count == '0);
  // Count is one bit wider than the pointers, so a full store is DEPTH exactly
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign push      = in_valid && in_ready;
  // Refill the output register whenever it is free or being taken
  assign pop       = !mem_empty && (!out_valid || out_ready);

  always_ff @(posedge sys_clk) begin
    if (push && ce) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (ce) begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr   <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
        out_data <= mem[rd_ptr];
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
      if (pop) begin
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end

endmodule // smp_fifo

`default_nettype wire

// ===== rtl/smp_bit_timer.sv
// Purpose: Reload counter whose overflows, halved, give the bit clock.
// Assumes: tick is a one-cycle enable at the timer clock rate.
// Notes: A forced reload also phases the halving so the first bit tick
//        comes one overflow later, half a bit time.
`default_nettype none

module smp_bit_timer #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Timer controls
  input  wire logic         tick,
  input  wire logic [W-1:0] reload_value,
  input  wire logic         force_reload,
  // Result
  output logic              overflow,
  output logic              bit_tick
);

  logic [W-1:0] count;
  logic         half;

  assign overflow = tick && (count == {W{1'b1}});
  assign bit_tick = overflow && half;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count <= '0;
      half  <= 1'b0;
    end else if (ce) begin
      if (force_reload) begin
        count <= reload_value;
        half  <= 1'b1;
      end else if (overflow) begin
        count <= reload_value;
        half  <= !half;
      end else if (tick) begin
        count <= count + 1'b1;
      end
    end
  end

endmodule // smp_bit_timer

`default_nettype wire

// ===== rtl/smp_uart.sv
// Purpose: Serial port with 8/9-bit frames and address filtering on receive.
// Assumes: Register access by an 8-bit special-register strobe bus; the
//          timer clock enable and its reload value come from outside.
// Notes: Transmit bytes queue in a FIFO; its ready is a port so the writer
//        can hold off instead of losing a byte.
`include "smp_defs.svh"
`default_nettype none

module smp_uart #(
  parameter int TX_FIFO_DEPTH = `SMP_TX_FIFO_DEPTH
) (
  // Clock, reset, enable
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Register bus
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  output logic            tx_buffer_ready,
  // Baud timer inputs
  input  wire logic       timer_tick,
  input  wire logic       timer_run,
  input  wire logic [7:0] baud_reload_value,
  // Interrupt request
  input  wire logic       irq_enable,
  output logic            serial_irq_req,
  // Serial pins
  input  wire logic       serial_in_pin,
  output logic            serial_out_pin
);

  // ==========================================================
  // Control register state
  logic       frame_format_select;
  logic       match_check_enable;
  logic       receive_enable_bit;
  logic       tx_ninth_bit;
  logic       rx_ninth_bit;
  logic       tx_done_flag;
  logic       rx_done_flag;
  logic [7:0] rx_latch;

  wire        wr_ctrl;
  wire        wr_buf;
  wire        rd_ctrl;
  wire        rd_buf;
  wire  [7:0] ctrl_view;
  wire  [7:0] read_mux;

  // ==========================================================
  // Register decode
  assign wr_ctrl = sfr_wr && (sfr_addr == `SMP_ADDR_CTRL);
  assign wr_buf  = sfr_wr && (sfr_addr == `SMP_ADDR_BUF);
  assign rd_ctrl = sfr_rd && (sfr_addr == `SMP_ADDR_CTRL);
  assign rd_buf  = sfr_rd && (sfr_addr == `SMP_ADDR_BUF);

  assign ctrl_view = {frame_format_select,
                      1'b1,
                      match_check_enable,
                      receive_enable_bit,
                      tx_ninth_bit,
                      rx_ninth_bit,
                      tx_done_flag,
                      rx_done_flag};

  // Transmit register is write-only; buffer reads see the receive latch
  assign read_mux = rd_ctrl ? ctrl_view :
                    rd_buf  ? rx_latch  : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sfr_rdata <= 8'h00;
    end else if (ce && sfr_rd) begin
      sfr_rdata <= read_mux;
    end
  end

  // ==========================================================
  // Transmit FIFO
  logic       txq_valid;
  logic       txq_ready;
  logic [7:0] txq_data;

  smp_fifo #(
    .WIDTH (`SMP_DATA_BITS),
    .DEPTH (TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .ce        (ce),
    .in_valid  (wr_buf),
    .in_ready  (tx_buffer_ready),
    .in_data   (sfr_wdata),
    .out_valid (txq_valid),
    .out_ready (txq_ready),
    .out_data  (txq_data)
  );

  // ==========================================================
  // Bit timers
  wire timer_step;
  wire tx_bit_tick;
  wire rx_bit_tick;
  wire rx_force_reload;

  assign timer_step = timer_run && timer_tick;

  // Transmit timer runs free; its phase is never disturbed by receive
  smp_bit_timer #(
    .W (8)
  ) u_tx_timer (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .ce           (ce),
    .tick         (timer_step),
    .reload_value (baud_reload_value),
    .force_reload (1'b0),
    .overflow     (),
    .bit_tick     (tx_bit_tick)
  );

  smp_bit_timer #(
    .W (8)
  ) u_rx_timer (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .ce           (ce),
    .tick         (timer_step),
    .reload_value (baud_reload_value),
    .force_reload (rx_force_reload),
    .overflow     (),
    .bit_tick     (rx_bit_tick)
  );

  // ==========================================================
  // Transmitter
  smp_pkg::smp_tx_state_t tx_state;
  smp_pkg::smp_tx_state_t next_tx_state;
  logic [7:0]             tx_shift;
  logic                   tx_ninth_latched;
  logic [2:0]             tx_count;
  wire                    tx_done_set;
  wire                    tx_take;

  assign txq_ready = (tx_state == smp_pkg::SMP_TX_IDLE);
  assign tx_take   = txq_ready && txq_valid;

  // Last data bit ends: ninth bit in 9-bit frames, else stop bit begins
  always_comb begin
    next_tx_state = tx_state;
    unique case (tx_state)
      smp_pkg::SMP_TX_IDLE: begin
        if (tx_take) begin
          next_tx_state = smp_pkg::SMP_TX_WAIT;
        end
      end
      smp_pkg::SMP_TX_WAIT: begin
        if (tx_bit_tick) begin
          next_tx_state = smp_pkg::SMP_TX_START;
        end
      end
      smp_pkg::SMP_TX_START: begin
        if (tx_bit_tick) begin
          next_tx_state = smp_pkg::SMP_TX_DATA;
        end
      end
      smp_pkg::SMP_TX_DATA: begin
        if (tx_bit_tick && (tx_count == 3'h7)) begin
          next_tx_state = frame_format_select ? smp_pkg::SMP_TX_NINTH
                                              : smp_pkg::SMP_TX_STOP;
        end
      end
      smp_pkg::SMP_TX_NINTH: begin
        if (tx_bit_tick) begin
          next_tx_state = smp_pkg::SMP_TX_STOP;
        end
      end
      smp_pkg::SMP_TX_STOP: begin
        if (tx_bit_tick) begin
          next_tx_state = smp_pkg::SMP_TX_IDLE;
        end
      end
      default: begin
        next_tx_state = smp_pkg::SMP_TX_IDLE;
      end
    endcase
  end

  // Flag rises as the stop bit goes out, in both frame modes
  assign tx_done_set = tx_bit_tick && (next_tx_state == smp_pkg::SMP_TX_STOP)
                       && (tx_state != smp_pkg::SMP_TX_STOP);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_state         <= smp_pkg::SMP_TX_IDLE;
      tx_shift         <= 8'h00;
      tx_ninth_latched <= 1'b0;
      tx_count         <= 3'h0;
      serial_out_pin   <= 1'b1;
    end else if (ce) begin
      tx_state <= next_tx_state;
      if (tx_take) begin
        tx_shift         <= txq_data;
        tx_ninth_latched <= tx_ninth_bit;
        tx_count         <= 3'h0;
      end else if (tx_bit_tick) begin
        unique case (tx_state)
          smp_pkg::SMP_TX_WAIT: begin
            serial_out_pin <= 1'b0;
          end
          smp_pkg::SMP_TX_START: begin
            serial_out_pin <= tx_shift[0];
            tx_shift       <= {1'b0, tx_shift[7:1]};
          end
          smp_pkg::SMP_TX_DATA: begin
            tx_count <= tx_count + 3'h1;
            if (tx_count == 3'h7) begin
              serial_out_pin <= frame_format_select ? tx_ninth_latched : 1'b1;
            end else begin
              serial_out_pin <= tx_shift[0];
              tx_shift       <= {1'b0, tx_shift[7:1]};
            end
          end
          smp_pkg::SMP_TX_NINTH: begin
            serial_out_pin <= 1'b1;
          end
          default: begin
            serial_out_pin <= 1'b1;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Receive pin synchroniser
  logic rx_meta;
  logic rx_sync;
  logic rx_prev;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end else if (ce) begin
      rx_meta <= serial_in_pin;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  // ==========================================================
  // Receiver
  smp_pkg::smp_rx_state_t rx_state;
  smp_pkg::smp_rx_state_t next_rx_state;
  logic [7:0]             rx_shift;
  logic                   rx_ninth_sampled;
  logic [2:0]             rx_count;
  wire                    rx_start_edge;
  wire                    rx_check_bit;
  wire                    rx_load;

  // Falling edge while idle and enabled marks a start condition
  assign rx_start_edge   = (rx_state == smp_pkg::SMP_RX_IDLE) && receive_enable_bit
                           && rx_prev && !rx_sync;
  assign rx_force_reload = rx_start_edge;

  // Timer phased so every bit tick lands mid-bit after the edge
  always_comb begin
    next_rx_state = rx_state;
    unique case (rx_state)
      smp_pkg::SMP_RX_IDLE: begin
        if (rx_start_edge) begin
          next_rx_state = smp_pkg::SMP_RX_START;
        end
      end
      smp_pkg::SMP_RX_START: begin
        if (rx_bit_tick) begin
          // A glitch that is high again at mid-start is not a frame
          next_rx_state = rx_sync ? smp_pkg::SMP_RX_IDLE : smp_pkg::SMP_RX_DATA;
        end
      end
      smp_pkg::SMP_RX_DATA: begin
        if (rx_bit_tick && (rx_count == 3'h7)) begin
          next_rx_state = frame_format_select ? smp_pkg::SMP_RX_NINTH
                                              : smp_pkg::SMP_RX_STOP;
        end
      end
      smp_pkg::SMP_RX_NINTH: begin
        if (rx_bit_tick) begin
          next_rx_state = smp_pkg::SMP_RX_STOP;
        end
      end
      smp_pkg::SMP_RX_STOP: begin
        if (rx_bit_tick) begin
          next_rx_state = smp_pkg::SMP_RX_IDLE;
        end
      end
      default: begin
        next_rx_state = smp_pkg::SMP_RX_IDLE;
      end
    endcase
  end

  // Ninth bit in 9-bit mode, stop bit in 8-bit mode
  assign rx_check_bit = frame_format_select ? rx_ninth_sampled : rx_sync;

  // A full latch blocks the load, so the first byte survives overrun
  assign rx_load = (rx_state == smp_pkg::SMP_RX_STOP) && rx_bit_tick
                   && !rx_done_flag
                   && (!match_check_enable || rx_check_bit);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_state         <= smp_pkg::SMP_RX_IDLE;
      rx_shift         <= 8'h00;
      rx_ninth_sampled <= 1'b0;
      rx_count         <= 3'h0;
    end else if (ce) begin
      rx_state <= next_rx_state;
      if (rx_start_edge) begin
        rx_count <= 3'h0;
      end else if (rx_bit_tick) begin
        if (rx_state == smp_pkg::SMP_RX_DATA) begin
          rx_shift <= {rx_sync, rx_shift[7:1]};
          rx_count <= rx_count + 3'h1;
        end
        if (rx_state == smp_pkg::SMP_RX_NINTH) begin
          rx_ninth_sampled <= rx_sync;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_latch <= 8'h00;
    end else if (ce && rx_load) begin
      rx_latch <= rx_shift;
    end
  end

  // ==========================================================
  // Control register
  // Hardware sets win over a software clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frame_format_select <= 1'((`SMP_CTRL_RESET >> `SMP_CTRL_MODE) & 8'h01);
      match_check_enable  <= 1'b0;
      receive_enable_bit  <= 1'b0;
      tx_ninth_bit        <= 1'b0;
      rx_ninth_bit        <= 1'b0;
      tx_done_flag        <= 1'b0;
      rx_done_flag        <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        frame_format_select <= sfr_wdata[`SMP_CTRL_MODE];
        match_check_enable  <= sfr_wdata[`SMP_CTRL_MCE];
        receive_enable_bit  <= sfr_wdata[`SMP_CTRL_REN];
        tx_ninth_bit        <= sfr_wdata[`SMP_CTRL_TB8];
      end
      if (rx_load) begin
        rx_ninth_bit <= rx_check_bit;
      end else if (wr_ctrl) begin
        rx_ninth_bit <= sfr_wdata[`SMP_CTRL_RB8];
      end
      // Only a register write lowers these flags
      if (tx_done_set) begin
        tx_done_flag <= 1'b1;
      end else if (wr_ctrl) begin
        tx_done_flag <= sfr_wdata[`SMP_CTRL_TI];
      end
      if (rx_load) begin
        rx_done_flag <= 1'b1;
      end else if (wr_ctrl) begin
        rx_done_flag <= sfr_wdata[`SMP_CTRL_RI];
      end
    end
  end

  // ==========================================================
  // Interrupt request
  // Level request; the interrupt controller handles vectoring
  assign serial_irq_req = irq_enable && (tx_done_flag || rx_done_flag);

endmodule // smp_uart

`default_nettype wire

// ===== tb/smp_uart_asserts.sv
// Purpose: Port-level assertions for the serial port.
// Assumes: timer_tick every cycle and reload 0xFC, so 8 cycles a bit.
// Notes: Bound to every smp_uart instance.
`include "smp_defs.svh"
`default_nettype none

module smp_uart_asserts #(
  parameter int TX_FIFO_DEPTH = 8
) (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       tx_buffer_ready,
  input wire logic       timer_tick,
  input wire logic       timer_run,
  input wire logic [7:0] baud_reload_value,
  input wire logic       irq_enable,
  input wire logic       serial_irq_req,
  input wire logic       serial_in_pin,
  input wire logic       serial_out_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Helpers
  localparam int START_MAX = 24;
  localparam int IDLE_MIN  = 96;
  logic [7:0] idle_cnt;
  wire logic  rd_ctrl = ce && sfr_rd && sfr_addr == `SMP_ADDR_CTRL;
  wire logic  wr_ctrl = ce && sfr_wr && sfr_addr == `SMP_ADDR_CTRL;
  wire logic  rd_none = ce && sfr_rd && sfr_addr != `SMP_ADDR_CTRL && sfr_addr != `SMP_ADDR_BUF;

  // Longer than any high stretch inside traffic, so the sender is idle
  always_ff @(posedge sys_clk) begin
    if (rst || !serial_out_pin) idle_cnt <= 8'h00;
    else if (idle_cnt != 8'hFF) idle_cnt <= idle_cnt + 8'h01;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_idle_write;
    ce && sfr_wr && sfr_addr == `SMP_ADDR_BUF && tx_buffer_ready && idle_cnt >= IDLE_MIN;
  endsequence
  sequence s_start_bit;
    !serial_out_pin [*8];
  endsequence

  // ==========================================================
  // Assertions
  chk_reset_values: assert property ($fell(rst) |-> sfr_rdata == 8'h00 && serial_out_pin
    && tx_buffer_ready && !serial_irq_req) else $error("outputs wrong after reset");
  chk_write_starts: assert property (s_idle_write |-> ##[1:START_MAX] s_start_bit)
    else $error("buffer write did not start a frame");
  chk_bit_hold: assert property ($changed(serial_out_pin) |=> $stable(serial_out_pin) [*7])
    else $error("serial bit shorter than a bit time");
  chk_bit6_one: assert property (rd_ctrl |=> sfr_rdata[6])
    else $error("control bit 6 read as 0");
  chk_unmapped_zero: assert property (rd_none |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_holds: assert property (!(ce && sfr_rd) |=> $stable(sfr_rdata))
    else $error("read data changed without a read");
  chk_irq_gate: assert property (!irq_enable |-> !serial_irq_req)
    else $error("interrupt request while disabled");
  chk_irq_sticky: assert property ((serial_irq_req && !wr_ctrl) ##1 irq_enable
    |-> serial_irq_req) else $error("done flag cleared without a write");
endmodule // smp_uart_asserts

bind smp_uart smp_uart_asserts #(.TX_FIFO_DEPTH(TX_FIFO_DEPTH)) i_smp_uart_asserts (
  .sys_clk, .rst, .ce, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .tx_buffer_ready,
  .timer_tick, .timer_run, .baud_reload_value, .irq_enable, .serial_irq_req, .serial_in_pin,
  .serial_out_pin);

`default_nettype wire

// ===== tb/smp_peer.sv
// Purpose: Remote serial node: sends frames and collects received ones.
// Assumes: Bit time of BIT_CYC system clocks, line idles high.
// Notes: Received frames queue as {ninth or stop, byte}.
`default_nettype none

module smp_peer #(
  parameter int BIT_CYC = 8
) (
  // Clock and mode
  input  wire logic sys_clk,
  input  wire logic nine,
  // Serial lines
  input  wire logic line_in,
  output var  logic line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] rx_q[$];
  logic [8:0] fr;

  initial line_out = 1'b1;

  // Always 11 slots; in 8-bit mode the last is idle line
  task automatic send(input logic [7:0] d, input logic b9, input logic stp);
    logic [10:0] bits;
    bits = nine ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(negedge sys_clk);
      line_out = bits[i];
      repeat (BIT_CYC - 1) @(negedge sys_clk);
    end
    // A low stop bit must not leave the line low, or the next start is lost
    @(negedge sys_clk);
    line_out = 1'b1;
  endtask

  // Samples at bit centres from the start edge
  always begin
    @(negedge line_in);
    repeat (BIT_CYC / 2) @(posedge sys_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CYC) @(posedge sys_clk);
      fr[i] = line_in;
    end
    rx_q.push_back(fr);
  end
endmodule // smp_peer

`default_nettype wire

// ===== tb/smp_uart_test.sv
// Purpose: Directed tests of registers, transmit, receive and filtering.
// Assumes: Timer ticks every cycle, reload 0xFC, 8 cycles a bit.
// Notes: Inputs change on the falling edge.
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end

module smp_uart_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 8;
  localparam logic [7:0] RC [7] = '{8'h00, 8'h10, 8'h11, 8'h30, 8'h30, 8'hB0, 8'hB0};
  localparam logic [7:0] RD [7] = '{8'h5A, 8'h3C, 8'hC3, 8'h77, 8'h77, 8'h12, 8'h34};
  localparam logic [6:0] R9 = 7'b1000000;
  localparam logic [6:0] RS = 7'b0110111;
  localparam logic [7:0] EC [7] = '{8'h40, 8'h55, 8'h51, 8'h70, 8'h75, 8'hF0, 8'hF5};
  localparam logic [7:0] EB [7] = '{8'h00, 8'h3C, 8'h3C, 8'h3C, 8'h77, 8'h77, 8'h34};
  logic       sys_clk, rst, sfr_wr, sfr_rd, irq_enable, nine;
  logic [7:0] sfr_addr, sfr_wdata, rd;
  wire logic [7:0] sfr_rdata;
  wire logic  tx_buffer_ready, serial_irq_req, serial_in_pin, serial_out_pin;
  int         err_count, checks, cyc, n;

  smp_uart #(.TX_FIFO_DEPTH(8)) i_smp_uart (.sys_clk(sys_clk), .rst(rst), .ce(1'b1),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .tx_buffer_ready(tx_buffer_ready), .timer_tick(1'b1),
    .timer_run(1'b1), .baud_reload_value(8'hFC), .irq_enable(irq_enable),
    .serial_irq_req(serial_irq_req), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin));
  smp_peer #(.BIT_CYC(BIT)) i_smp_peer (.sys_clk(sys_clk), .nine(nine),
    .line_in(serial_out_pin), .line_out(serial_in_pin));

  // ==========================================================
  // Access tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge sys_clk);
    sfr_wr = 1'b0;
  endtask
  task automatic chk_reg(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge sys_clk);
    sfr_rd = 1'b0;
    `CHK(nm, e, sfr_rdata)
  endtask
  task automatic tx_one(input logic [7:0] ctl, input logic [7:0] d);
    wr(8'h98, ctl);
    nine = ctl[7];
    i_smp_peer.rx_q.delete();
    wr(8'h99, d);
    n = 0;
    while (serial_out_pin && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    repeat (BIT * (ctl[7] ? 9 : 8) + 2) @(negedge sys_clk);
    chk_reg("tx_done early", 8'h98, ctl | 8'h40);
    repeat (BIT - 2) @(negedge sys_clk);
    chk_reg("tx_done set", 8'h98, ctl | 8'h42);
    repeat (2 * BIT) @(negedge sys_clk);
    `CHK("tx frame", {ctl[7] ? ctl[3] : 1'b1, d}, i_smp_peer.rx_q[0])
    wr(8'h98, ctl);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      end_of_test();
    end
  end

  // ==========================================================
  // Tests
  initial begin
    {rst, sfr_wr, sfr_rd, irq_enable, nine, sfr_addr, sfr_wdata} = {5'b10010, 16'h0000};
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    chk_reg("ctrl reset", 8'h98, 8'h40);
    wr(8'h98, 8'h00);
    chk_reg("ctrl bit6", 8'h98, 8'h40);
    wr(8'h98, 8'hBC);
    chk_reg("ctrl rw", 8'h98, 8'hFC);
    wr(8'h9A, 8'hFF);
    chk_reg("unmapped", 8'h9A, 8'h00);
    chk_reg("rx latch reset", 8'h99, 8'h00);
    $display("register test done");
    // Transmit timer starts from zero; let it run and the line idle long enough
    repeat (40 * BIT) @(negedge sys_clk);
    tx_one(8'h00, 8'hA5);
    tx_one(8'h88, 8'h3C);
    tx_one(8'h80, 8'hC3);
    tx_one(8'h08, 8'h5A);
    $display("transmit test done");
    wr(8'h98, 8'h00);
    nine = 1'b0;
    i_smp_peer.rx_q.delete();
    n = 0;
    while (tx_buffer_ready && n < 20) begin
      wr(8'h99, 8'h10 + 8'(n));
      n++;
    end
    wr(8'h99, 8'hEE);
    `CHK("fifo depth", 10, n)
    repeat (12 * BIT * 11) @(negedge sys_clk);
    `CHK("frames sent", n, i_smp_peer.rx_q.size())
    for (int i = 0; i < n && i < i_smp_peer.rx_q.size(); i++)
      `CHK("fifo order", {1'b1, 8'h10 + 8'(i)}, i_smp_peer.rx_q[i])
    wr(8'h98, 8'h00);
    $display("fifo test done");
    for (int i = 0; i < 7; i++) begin
      wr(8'h98, RC[i]);
      nine = RC[i][7];
      i_smp_peer.send(RD[i], R9[i], RS[i]);
      repeat (BIT) @(negedge sys_clk);
      chk_reg("rx ctrl", 8'h98, EC[i]);
      chk_reg("rx buf", 8'h99, EB[i]);
      if (i == 1) begin
        `CHK("irq on", 1'b1, serial_irq_req)
        irq_enable = 1'b0;
        @(negedge sys_clk);
        `CHK("irq masked", 1'b0, serial_irq_req)
        irq_enable = 1'b1;
      end
    end
    wr(8'h98, 8'h90);
    i_smp_peer.send(8'h56, 1'b0, 1'b1);
    repeat (BIT) @(negedge sys_clk);
    chk_reg("matched data", 8'h98, 8'hD1);
    chk_reg("matched buf", 8'h99, 8'h56);
    wr(8'h98, 8'h00);
    @(negedge sys_clk);
    `CHK("irq cleared", 1'b0, serial_irq_req)
    $display("receive test done");
    end_of_test();
  end
endmodule // smp_uart_test

`default_nettype wire
